// >>> pmr_defs.vh
`ifndef PMR_DEFS_VH
`define PMR_DEFS_VH
// Field positions, bit 1 is the most significant bit (index 15)
`define PMR_IE_BIT 15
`define PMR_VEC_BIT 14
`define PMR_RSV_HI 13
`define PMR_RSV_LO 8
`define PMR_SET_HI 7
`define PMR_SET_LO 5
`define PMR_IOMAP_BIT 4
`define PMR_EXCH_BIT 3
`define PMR_SEG_BIT 2
`define PMR_ERL_HI 1
`define PMR_ERL_LO 0
// Positions a load or direct write may change: bits 1, 2 and 12 to 16
`define PMR_WR_MASK 16'hc01f
// Reset value: normal operating setting, register set zero
`define PMR_RESET 16'hc01f
// Addressing modes
`define PMR_MODE_S 2'h0
`define PMR_MODE_R 2'h1
`define PMR_MODE_V 2'h2
`define PMR_MODE_I 2'h3
// Opcodes on the instruction port
`define PMR_OP_NONE 4'h0
`define PMR_OP_ALLOW 4'h1
`define PMR_OP_BLOCK 4'h2
`define PMR_OP_STD 4'h3
`define PMR_OP_VECT 4'h4
`define PMR_OP_CHKCLR 4'h5
`define PMR_OP_CHKIN 4'h6
`define PMR_OP_CHKOUT 4'h7
`define PMR_OP_LOAD 4'h8
`define PMR_OP_WRITE 4'h9
`define PMR_OP_XCHG 4'ha
`endif

// >>> pmr_mode_check.v
`timescale 1ns/1ps
`default_nettype none
`include "pmr_defs.vh"
// Decides whether an opcode is legal in the current addressing mode
module pmr_mode_check (
    input wire [3:0] opCode,
    input wire [1:0] addrMode,
    output reg opLegal
);
    wire isVI;
    assign isVI = (addrMode == `PMR_MODE_V) || (addrMode == `PMR_MODE_I);
    // Legality table per opcode
    always @* begin
        case (opCode)
            `PMR_OP_ALLOW, `PMR_OP_BLOCK: opLegal = 1'h1;
            `PMR_OP_CHKIN, `PMR_OP_CHKOUT, `PMR_OP_CHKCLR: opLegal = 1'h1;
            `PMR_OP_STD, `PMR_OP_VECT: opLegal = (addrMode != `PMR_MODE_I);
            `PMR_OP_LOAD: opLegal = isVI;
            `PMR_OP_WRITE: opLegal = isVI;
            `PMR_OP_XCHG: opLegal = 1'h1;
            default: opLegal = 1'h0;
        endcase
    end
endmodule // pmr_mode_check
`default_nettype wire

// >>> pmr_state_reg.v
`timescale 1ns/1ps
`default_nettype none
`include "pmr_defs.vh"
// Summary of operation
// - Bit 1 gates interrupts: 0 blocks all, 1 allows them.
// - Bit 2 selects standard (0) or vectored (1) interrupt handling.
// - Bits 9 to 11 hold the active register set and only process exchange changes them.
// - Bit 12 selects unmapped (0) or mapped (1) I/O transfers.
// - Bit 13 enables process exchange when 1; the exchange op here is taken whatever bit 13 holds.
// - Bit 14 turns memory segmentation on when 1.
// - Bits 15 to 16 set error reporting: none, parity only, unrecovered only, all.
// - The normal setting is 11000000 in bits 1 to 8 and 11111 in bits 12 to 16.
// - The allow op sets bit 1 and the block op clears it, in every mode.
// - Enter vectored sets bit 2 and enter standard clears it, only in S, R and V modes.
// - The check flag clear op zeroes bits 15 to 16 and holds off interrupts one instruction.
// - Dedicated ops, legal in all modes, enter and leave machine check mode.
// - The status word load, legal only in V and I modes, fills the register from memory.
// - The register is directly readable and writable only in V and I modes.
module pmr_state_reg (
    input wire clk,
    input wire rst,
    input wire opValid,
    input wire [3:0] opCode,
    input wire [15:0] opData,
    input wire [2:0] newRegSet,
    input wire [1:0] addrMode,
    input wire instrDone,
    input wire readReq,
    output reg [15:0] readData,
    output reg readValid,
    output reg opIllegal,
    output reg interruptAllow,
    output reg vectoredMode,
    output reg [2:0] active_register_set,
    output reg io_mapping_select,
    output reg process_exchange_enable,
    output reg segmentEnable,
    output reg [1:0] error_report_level,
    output reg checkModeActive
);
    // Stored register word and the two side states
    reg [15:0] flags_reg;
    reg [15:0] flags_next;
    reg holdOff_reg;
    reg holdOff_next;
    reg checkMode_reg;
    reg checkMode_next;
    // Legality and decoded op strobes
    wire opLegal;
    wire isVI;
    wire opTaken;
    wire doAllow;
    wire doBlock;
    wire doStd;
    wire doVect;
    wire doClear;
    wire doChkIn;
    wire doChkOut;
    wire doLoad;
    wire doWrite;
    wire doExch;
    // Word that a load or direct write would leave behind
    wire [15:0] mergedWord;
    genvar bitIdx;

    // Positions that a load or direct write may change
    localparam [15:0] WR_MASK = `PMR_WR_MASK;

    // Direct access and reads only in the V and I modes
    assign isVI = (addrMode == `PMR_MODE_V) || (addrMode == `PMR_MODE_I);

    pmr_mode_check uCheck (
        .opCode(opCode),
        .addrMode(addrMode),
        .opLegal(opLegal)
    );

    // An op counts only when the current mode allows it; refused ops decode to nothing
    assign opTaken = opValid & opLegal;
    assign doAllow = opTaken & (opCode == `PMR_OP_ALLOW);
    assign doBlock = opTaken & (opCode == `PMR_OP_BLOCK);
    assign doStd = opTaken & (opCode == `PMR_OP_STD);
    assign doVect = opTaken & (opCode == `PMR_OP_VECT);
    assign doClear = opTaken & (opCode == `PMR_OP_CHKCLR);
    assign doChkIn = opTaken & (opCode == `PMR_OP_CHKIN);
    assign doChkOut = opTaken & (opCode == `PMR_OP_CHKOUT);
    assign doLoad = opTaken & (opCode == `PMR_OP_LOAD);
    assign doWrite = opTaken & (opCode == `PMR_OP_WRITE);
    assign doExch = opTaken & (opCode == `PMR_OP_XCHG);

    // Per-bit merge: writable positions take the data, the rest keep their value.
    // Keeping the set field here is what stops a status word load from moving it.
    generate
        for (bitIdx = 0; bitIdx < 16; bitIdx = bitIdx + 1) begin : gMerge
            if (WR_MASK[bitIdx]) begin : gTake
                assign mergedWord[bitIdx] = opData[bitIdx];
            end else begin : gKeep
                assign mergedWord[bitIdx] = flags_reg[bitIdx];
            end
        end
    endgenerate

    // Next register word; at most one strobe is high since one op comes per cycle
    always @* begin
        flags_next = flags_reg;
        if (doAllow) begin
            flags_next[`PMR_IE_BIT] = 1'h1;
        end
        if (doBlock) begin
            flags_next[`PMR_IE_BIT] = 1'h0;
        end
        if (doVect) begin
            flags_next[`PMR_VEC_BIT] = 1'h1;
        end
        if (doStd) begin
            flags_next[`PMR_VEC_BIT] = 1'h0;
        end
        if (doClear) begin
            flags_next[`PMR_ERL_HI:`PMR_ERL_LO] = 2'h0;
        end
        if (doLoad || doWrite) begin
            flags_next = mergedWord;
        end
        if (doExch) begin
            flags_next[`PMR_SET_HI:`PMR_SET_LO] = newRegSet;
        end
        // Reserved positions never hold a one, whatever software wrote
        flags_next[`PMR_RSV_HI:`PMR_RSV_LO] = 6'h00;
    end

    // Hold-off ends when the instruction after the clear op retires
    always @* begin
        holdOff_next = holdOff_reg;
        if (instrDone && holdOff_reg) begin
            holdOff_next = 1'h0;
        end
        // A retire on the clear op's own edge belongs to the clear op itself
        if (doClear) begin
            holdOff_next = 1'h1;
        end
    end

    // Machine check mode is its own flag, outside the register word
    always @* begin
        checkMode_next = checkMode_reg;
        if (doChkIn) begin
            checkMode_next = 1'h1;
        end
        if (doChkOut) begin
            checkMode_next = 1'h0;
        end
    end

    // Register word; reset lands on the normal operating setting with set zero
    always @(posedge clk) begin
        if (rst) begin
            flags_reg <= `PMR_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Hold-off state
    always @(posedge clk) begin
        if (rst) begin
            holdOff_reg <= 1'h0;
        end else begin
            holdOff_reg <= holdOff_next;
        end
    end

    // Check mode state
    always @(posedge clk) begin
        if (rst) begin
            checkMode_reg <= 1'h0;
        end else begin
            checkMode_reg <= checkMode_next;
        end
    end

    // Interrupt controls track the next word so they change on the op's own edge.
    // Hold-off masks the gate only; the stored enable bit is left as software set it.
    always @(posedge clk) begin
        if (rst) begin
            interruptAllow <= 1'h0;
            vectoredMode <= 1'h0;
        end else begin
            interruptAllow <= flags_next[`PMR_IE_BIT] & ~holdOff_next;
            vectoredMode <= flags_next[`PMR_VEC_BIT];
        end
    end

    // Field outputs, each a copy of its position in the next word
    always @(posedge clk) begin
        if (rst) begin
            active_register_set <= 3'h0;
            io_mapping_select <= 1'h0;
            process_exchange_enable <= 1'h0;
            segmentEnable <= 1'h0;
            error_report_level <= 2'h0;
        end else begin
            active_register_set <= flags_next[`PMR_SET_HI:`PMR_SET_LO];
            io_mapping_select <= flags_next[`PMR_IOMAP_BIT];
            process_exchange_enable <= flags_next[`PMR_EXCH_BIT];
            segmentEnable <= flags_next[`PMR_SEG_BIT];
            error_report_level <= flags_next[`PMR_ERL_HI:`PMR_ERL_LO];
        end
    end

    // Check mode status and the one-cycle refusal pulse
    always @(posedge clk) begin
        if (rst) begin
            checkModeActive <= 1'h0;
            opIllegal <= 1'h0;
        end else begin
            checkModeActive <= checkMode_next;
            opIllegal <= opValid & ~opLegal;
        end
    end

    // Read port: one-cycle answer showing the word as it stood before this edge.
    // Reads are refused outside V and I, and the data then reads zero.
    always @(posedge clk) begin
        if (rst) begin
            readValid <= 1'h0;
            readData <= 16'h0000;
        end else begin
            readValid <= readReq & isVI;
            readData <= (readReq && isVI) ? flags_reg : 16'h0000;
        end
    end
endmodule // pmr_state_reg
`default_nettype wire

// >>> pmr_state_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks, each op is judged at the edge after the one that takes it
module pmr_state_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic opValid,
    input wire logic [3:0] opCode,
    input wire logic [1:0] addrMode,
    input wire logic readReq,
    input wire logic readValid,
    input wire logic [15:0] readData,
    input wire logic opIllegal,
    input wire logic interruptAllow,
    input wire logic vectoredMode,
    input wire logic [2:0] active_register_set,
    input wire logic [1:0] error_report_level
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_inh; opValid && opCode == 4'h2 |=> !interruptAllow; endproperty
    a_inh: assert property (p_inh) else $error("block op left ints on");
    property p_vec; opValid && opCode == 4'h4 && addrMode != 2'h3 |=> vectoredMode; endproperty
    a_vec: assert property (p_vec) else $error("vectored not set");
    property p_ref; opValid && opCode == 4'h3 && addrMode == 2'h3
        |=> opIllegal && $stable(vectoredMode); endproperty
    a_ref: assert property (p_ref) else $error("standard op not refused");
    property p_clr; opValid && opCode == 4'h5 |=> error_report_level == 2'h0 && !interruptAllow;
    endproperty
    a_clr: assert property (p_clr) else $error("flag clear wrong");
    // Only the exchange op may move the set field
    property p_set; !(opValid && opCode == 4'ha) |=> $stable(active_register_set); endproperty
    a_set: assert property (p_set) else $error("set field moved");
    property p_ldw; opValid && opCode == 4'h8 && !addrMode[1] |=> opIllegal; endproperty
    a_ldw: assert property (p_ldw) else $error("load not refused");
    property p_rd; readReq |=> readValid == $past(addrMode[1]); endproperty
    a_rd: assert property (p_rd) else $error("read gating wrong");
    property p_rsv; readValid |-> readData[13:8] == 6'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule // pmr_state_asserts
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'h0, rst = 1'h1, opValid = 1'h0, instrDone = 1'h0, readReq = 1'h0;
    logic [3:0] opCode = 4'h0;
    logic [15:0] opData = 16'h0000, readData, e;
    logic [2:0] newRegSet = 3'h0, active_register_set;
    logic [1:0] addrMode = 2'h2, error_report_level;
    logic readValid, opIllegal, interruptAllow, vectoredMode, io_mapping_select;
    logic process_exchange_enable, segmentEnable, checkModeActive;
    int n_errors = 0, total_checks = 0;
    pmr_state_reg u_dut (
        .clk(clk),
        .rst(rst),
        .opValid(opValid),
        .opCode(opCode),
        .opData(opData),
        .newRegSet(newRegSet),
        .addrMode(addrMode),
        .instrDone(instrDone),
        .readReq(readReq),
        .readData(readData),
        .readValid(readValid),
        .opIllegal(opIllegal),
        .interruptAllow(interruptAllow),
        .vectoredMode(vectoredMode),
        .active_register_set(active_register_set),
        .io_mapping_select(io_mapping_select),
        .process_exchange_enable(process_exchange_enable),
        .segmentEnable(segmentEnable),
        .error_report_level(error_report_level),
        .checkModeActive(checkModeActive)
    );
    // 20 MHz clock
    initial forever #25 clk = ~clk;
    // One op or read per call, driven on the falling edge so the rising edge sees it settled
    task automatic op(input logic [3:0] c, input logic [1:0] m);
        @(negedge clk);
        {opValid, opCode, addrMode} = {1'h1, c, m};
        @(negedge clk);
        opValid = 1'h0;
    endtask
    task automatic rd(input logic [1:0] m);
        @(negedge clk);
        {readReq, addrMode} = {1'h1, m};
        @(negedge clk);
        readReq = 1'h0;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        total_checks++;
        if (g !== x) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Direct writes keep the set field and never set the reserved bits
    function automatic logic [15:0] word(input logic [15:0] v, input logic [2:0] rs);
        return (v & 16'hc01f) | {8'h00, rs, 5'h00};
    endfunction
    // Field outputs expected for a register word, in port order
    function automatic logic [15:0] fields(input logic [15:0] w);
        return {6'h00, w[15:14], w[7:0]};
    endfunction
    // Field outputs as the design shows them
    function automatic logic [15:0] outs();
        return {6'h00, interruptAllow, vectoredMode, active_register_set, io_mapping_select,
            process_exchange_enable, segmentEnable, error_report_level};
    endfunction
    initial begin
        void'($urandom(14));
        repeat (5) @(negedge clk);
        rst = 1'h0;
        rd(2'h3);
        chk(readData, 16'hc01f);
        chk(outs(), fields(16'hc01f));
        rd(2'h0);
        chk(16'(readValid), 16'h0000);
        // Random exchange, load or write in V or I, the other refused in S or R, then readback in V or I
        for (int i = 0; i < 40; i++) begin
            opData = 16'($urandom);
            newRegSet = 3'($urandom);
            e = word(opData, newRegSet);
            op(4'ha, 2'($urandom));
            op(i[0] ? 4'h8 : 4'h9, {1'h1, 1'($urandom)});
            opData = ~opData;
            op(i[0] ? 4'h9 : 4'h8, {1'h0, 1'($urandom)});
            chk(16'(opIllegal), 16'h0001);
            rd({1'h1, 1'($urandom)});
            chk(readData, e);
            chk(outs(), fields(e));
        end
        // Hold-off after the flag clear lasts one retired instruction
        op(4'h1, 2'h0);
        op(4'h5, 2'h2);
        chk(16'({interruptAllow, error_report_level}), 16'h0000);
        instrDone = 1'h1;
        @(negedge clk);
        instrDone = 1'h0;
        chk(16'(interruptAllow), 16'h0001);
        op(4'h4, 2'h0);
        op(4'h3, 2'h3);
        chk(16'({vectoredMode, opIllegal}), 16'h0003);
        op(4'h3, 2'h1);
        chk(16'(vectoredMode), 16'h0000);
        op(4'h2, 2'h3);
        chk(16'(interruptAllow), 16'h0000);
        op(4'h6, 2'h0);
        chk(16'(checkModeActive), 16'h0001);
        op(4'h7, 2'h3);
        chk(16'(checkModeActive), 16'h0000);
        tally_and_finish();
    end
endmodule // tb_top
bind pmr_state_reg pmr_state_asserts u_chk (
    .clk(clk),
    .rst(rst),
    .opValid(opValid),
    .opCode(opCode),
    .addrMode(addrMode),
    .readReq(readReq),
    .readValid(readValid),
    .readData(readData),
    .opIllegal(opIllegal),
    .interruptAllow(interruptAllow),
    .vectoredMode(vectoredMode),
    .active_register_set(active_register_set),
    .error_report_level(error_report_level)
);
`default_nettype wire
